// ---- dps_pkg.sv ----
// Constants, register map and carrier types of the DP cycle poll scheduler.
package dps_pkg;

  // Table of slave entries.
  localparam int unsigned NUM_ENTRIES = 8;
  localparam int unsigned ENTRY_W     = 3;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_PERIOD   = 8'h04;
  localparam logic [7:0] OFF_STATUS   = 8'h08;
  localparam logic [7:0] OFF_MASK     = 8'h0C;
  localparam logic [7:0] OFF_ERRCODE  = 8'h10;
  localparam logic [7:0] OFF_PHASE    = 8'h14;
  localparam logic [7:0] OFF_ENTRY0   = 8'h20;
  localparam logic [7:0] OFF_ENTRY_END = 8'h40;

  // Values after reset.
  localparam logic [31:0] RST_CTRL   = 32'h0001_0100;
  localparam logic [31:0] RST_PERIOD = 32'h0003_0D40;
  localparam logic [31:0] RST_ENTRY  = 32'h0000_0001;
  localparam logic [2:0]  RST_MASK   = 3'h0;

  // Sticky status bit positions.
  localparam int unsigned ST_CYCLE_DONE = 0;
  localparam int unsigned ST_RESP_ERROR = 1;
  localparam int unsigned ST_DROPPED    = 2;

  // Error range and slave response status codes.
  localparam logic [7:0] ERR_RANGE                     = 8'h28;
  localparam logic [3:0] OK_STATUS                     = 4'h0;
  localparam logic [3:0] USER_ERROR_STATUS             = 4'h1;
  localparam logic [3:0] NO_RESOURCES_STATUS           = 4'h2;
  localparam logic [3:0] SERVICE_POINT_DISABLED_STATUS = 4'h3;
  localparam logic [3:0] DATA_LOW_STATUS               = 4'h8;
  localparam logic [3:0] NO_RESPONSE_READY_STATUS      = 4'h9;
  localparam logic [3:0] DATA_HIGH_STATUS              = 4'hA;
  localparam logic [3:0] NOT_RECEIVED_LOW_STATUS       = 4'hC;
  localparam logic [3:0] NOT_RECEIVED_HIGH_STATUS      = 4'hD;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Control register layout.
  typedef struct packed {
    logic [7:0] pad_hi;
    logic [7:0] diag_div;
    logic [7:0] cycles_per_task;
    logic [6:0] pad_lo;
    logic       enable;
  } dps_ctrl_t;

  // Slave entry register layout.
  typedef struct packed {
    logic       en;
    logic [7:0] pad;
    logic [6:0] slave_addr;
    logic [7:0] phase;
    logic [7:0] divisor;
  } dps_entry_t;

  // Poll request towards the bus engine.
  typedef struct packed {
    logic               valid;
    logic [ENTRY_W-1:0] entry;
    logic [6:0]         slave_addr;
  } dps_poll_t;

  // Answer from the bus engine.
  typedef struct packed {
    logic       valid;
    logic [3:0] status;
  } dps_resp_t;

  typedef enum logic [1:0] {S_IDLE, S_SCAN, S_WAIT} dps_state_t;

endpackage

// ---- dps_scheduler.sv ----
// DP cycle poll scheduler with AXI4-Lite registers and a level interrupt.
//
// Overview of operation
// [R1] Unexpected slave statuses are reported as error code 0x28 followed by the status.
// [R2] Data low, no response ready and OK statuses are never reported as errors.
// [R3] Each entry holds a divisor; it is polled once every divisor DP cycles.
// [R4] Each entry holds a phase offset choosing its cycle within the divisor period.
// [R5] Poll an entry when cycle counter modulo divisor equals its phase offset.
// [R6] The current poll phase of the running cycle is readable by software.
// [R7] A configurable number of DP cycles runs inside one task cycle.
// [R8] First cycle starts a timer of task period over cycle count; expiry starts next.
// [R9] A cycle start arriving while the previous cycle still runs is dropped.
// [R10] Sample entries follow their own interval and phase, so not every entry polls every cycle.
// [R11] Entries with phase offset zero are served before all other entries.
// [R12] Twice-sampled slaves use identical entries except phase offsets 0 and 1.
// [R13] A slave needing one image is configured once, interval 1, offset 0.
`timescale 1ns/1ps

module dps_scheduler (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Task start pin and bus engine
  input  wire logic              task_start,
  output dps_pkg::dps_poll_t     poll,
  input  wire dps_pkg::dps_resp_t resp,
  // Interrupt
  output logic                   irq
);

  // Bus side state.
  logic                      aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [7:0]                awaddr_q, awaddr_d;
  logic [31:0]               wdata_q, wdata_d;
  logic [3:0]                wstrb_q, wstrb_d;
  logic                      awready_q, awready_d, wready_q, wready_d;
  logic                      bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]                bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]               rdata_q, rdata_d;
  dps_pkg::dps_ctrl_t        ctrl_q, ctrl_d;
  logic [31:0]               period_q, period_d;
  logic [2:0]                status_q, status_d, mask_q, mask_d, st_set, st_clr;
  logic [31:0]               entry_q [dps_pkg::NUM_ENTRIES];
  logic [31:0]               entry_d [dps_pkg::NUM_ENTRIES];
  logic                      irq_q, irq_d;

  // Scheduler state.
  dps_pkg::dps_state_t       state_q, state_d;
  logic [3:0]                idx_q, idx_d;
  logic [7:0]                left_q, left_d;
  logic [31:0]               timer_q, timer_d;
  logic [15:0]               cyc_q, cyc_d;
  logic [19:0]               err_q, err_d;
  dps_pkg::dps_poll_t        poll_q, poll_d;
  logic                      ts_s1_q, ts_s2_q, ts_s3_q;

  // Derived terms.
  dps_pkg::dps_entry_t       cur;
  logic [7:0]                cur_div, cpt, ddiv;
  logic [31:0]               slice;
  logic [15:0]               cur_mod, phase_now;
  logic                      due, task_edge, tick, start_req, busy, is_err;

  // Merge a write with byte strobes into an old word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // The pin comes from another domain; the first stage feeds only the second.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ts_s1_q <= 1'b0;
      ts_s2_q <= 1'b0;
      ts_s3_q <= 1'b0;
    end else begin
      ts_s1_q <= task_start;
      ts_s2_q <= ts_s1_q;
      ts_s3_q <= ts_s2_q;
    end
  end

  // Scheduling terms; a zero divisor counts as one so the modulo stays defined.
  always_comb begin
    cur       = dps_pkg::dps_entry_t'(entry_q[idx_q[2:0]]);
    cur_div   = (cur.divisor == 8'h00) ? 8'h01 : cur.divisor;
    cur_mod   = cyc_q % {8'h00, cur_div};
    cpt       = (ctrl_q.cycles_per_task == 8'h00) ? 8'h01 : ctrl_q.cycles_per_task;
    ddiv      = (ctrl_q.diag_div == 8'h00) ? 8'h01 : ctrl_q.diag_div;
    phase_now = cyc_q % {8'h00, ddiv}; // R6
    slice     = period_q / {24'h00_0000, cpt}; // R8
    // Phase-zero entries go in the first pass, the rest in the second.
    due       = cur.en && (cur_mod == {8'h00, cur.phase}) // R3 R4 R5 R10
                && ((cur.phase == 8'h00) != idx_q[3]); // R11
    task_edge = ts_s2_q && !ts_s3_q && ctrl_q.enable;
    tick      = (left_q != 8'h00) && (timer_q == 32'h0000_0001);
    start_req = task_edge || tick;
    busy      = (state_q != dps_pkg::S_IDLE);
    is_err    = !(resp.status == dps_pkg::OK_STATUS
                  || resp.status == dps_pkg::DATA_LOW_STATUS
                  || resp.status == dps_pkg::NO_RESPONSE_READY_STATUS); // R2
  end

  // Cycle sequencing, timer and poll issue.
  always_comb begin
    state_d = state_q;
    idx_d   = idx_q;
    left_d  = left_q;
    timer_d = timer_q;
    cyc_d   = cyc_q;
    err_d   = err_q;
    poll_d  = poll_q;
    st_set  = 3'h0;
    // The timer only runs while the task cycle still has cycles left to start, whether or not a cycle is running.
    if (left_q != 8'h00) begin
      timer_d = (timer_q == 32'h0000_0001) ? slice : timer_q - 32'h0000_0001; // R8
    end
    if (task_edge) begin
      left_d  = cpt - 8'h01; // R7
      timer_d = (slice == 32'h0000_0000) ? 32'h0000_0001 : slice; // R8
    end else if (tick) begin
      left_d = left_q - 8'h01;
    end
    // A start that finds the previous cycle running is lost, never queued.
    if (start_req && busy) begin
      st_set[dps_pkg::ST_DROPPED] = 1'b1; // R9
    end
    case (state_q)
      dps_pkg::S_IDLE: begin
        if (start_req) begin
          state_d = dps_pkg::S_SCAN;
          idx_d   = 4'h0;
        end
      end
      dps_pkg::S_SCAN: begin
        if (due) begin
          poll_d  = '{valid: 1'b1, entry: idx_q[2:0], slave_addr: cur.slave_addr};
          state_d = dps_pkg::S_WAIT;
        end else if (idx_q == 4'hF) begin
          state_d = dps_pkg::S_IDLE;
          cyc_d   = cyc_q + 16'h0001; // R5
          st_set[dps_pkg::ST_CYCLE_DONE] = 1'b1;
        end else begin
          idx_d = idx_q + 4'h1;
        end
      end
      dps_pkg::S_WAIT: begin
        if (resp.valid) begin
          poll_d.valid = 1'b0;
          if (is_err) begin
            err_d = {1'b0, poll_q.entry, dps_pkg::ERR_RANGE, 4'h0, resp.status}; // R1
            st_set[dps_pkg::ST_RESP_ERROR] = 1'b1;
          end
          if (idx_q == 4'hF) begin
            state_d = dps_pkg::S_IDLE;
            cyc_d   = cyc_q + 16'h0001;
            st_set[dps_pkg::ST_CYCLE_DONE] = 1'b1;
          end else begin
            state_d = dps_pkg::S_SCAN;
            idx_d   = idx_q + 4'h1;
          end
        end
      end
      default: begin
        state_d = dps_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= dps_pkg::S_IDLE;
      idx_q   <= 4'h0;
      left_q  <= 8'h00;
      timer_q <= 32'h0000_0000;
      cyc_q   <= 16'h0000;
      err_q   <= 20'h0_0000;
      poll_q  <= '0;
    end else begin
      state_q <= state_d;
      idx_q   <= idx_d;
      left_q  <= left_d;
      timer_q <= timer_d;
      cyc_q   <= cyc_d;
      err_q   <= err_d;
      poll_q  <= poll_d;
    end
  end

  // AXI4-Lite slave; address and data are taken in either order.
  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d  = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d  = wdata_q;
    wstrb_d  = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    ctrl_d   = ctrl_q;
    period_d = period_q;
    mask_d   = mask_q;
    st_clr   = 3'h0;
    for (int i = 0; i < dps_pkg::NUM_ENTRIES; i++) begin
      entry_d[i] = entry_q[i];
    end
    if (s_axi_awvalid && awready_q) begin
      aw_got_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_got_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_got_q && w_got_q && !bvalid_q) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = dps_pkg::RESP_OKAY;
      case ({awaddr_q[7:2], 2'b00})
        dps_pkg::OFF_CTRL:    ctrl_d   = dps_pkg::dps_ctrl_t'(merge(ctrl_q, wdata_q, wstrb_q));
        dps_pkg::OFF_PERIOD:  period_d = merge(period_q, wdata_q, wstrb_q);
        dps_pkg::OFF_MASK:    mask_d   = wstrb_q[0] ? wdata_q[2:0] : mask_q;
        dps_pkg::OFF_STATUS, dps_pkg::OFF_ERRCODE, dps_pkg::OFF_PHASE: begin
        end
        default: begin
          if (awaddr_q >= dps_pkg::OFF_ENTRY0 && awaddr_q < dps_pkg::OFF_ENTRY_END) begin
            entry_d[awaddr_q[4:2]] = merge(entry_q[awaddr_q[4:2]], wdata_q, wstrb_q)
                                     & 32'h807F_FFFF;
          end else begin
            bresp_d = dps_pkg::RESP_DECERR;
          end
        end
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = dps_pkg::RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      case ({s_axi_araddr[7:2], 2'b00})
        dps_pkg::OFF_CTRL:    rdata_d = ctrl_q & 32'h00FF_FF01;
        dps_pkg::OFF_PERIOD:  rdata_d = period_q;
        dps_pkg::OFF_STATUS: begin
          rdata_d = {29'h0000_0000, status_q};
          st_clr  = 3'h7;
        end
        dps_pkg::OFF_MASK:    rdata_d = {29'h0000_0000, mask_q};
        dps_pkg::OFF_ERRCODE: rdata_d = {12'h000, err_q};
        dps_pkg::OFF_PHASE:   rdata_d = {phase_now[7:0], 8'h00, cyc_q}; // R6
        default: begin
          if (s_axi_araddr >= dps_pkg::OFF_ENTRY0 && s_axi_araddr < dps_pkg::OFF_ENTRY_END) begin
            rdata_d = entry_q[s_axi_araddr[4:2]];
          end else begin
            rresp_d = dps_pkg::RESP_DECERR;
          end
        end
      endcase
    end
    awready_d = !aw_got_d && !bvalid_d;
    wready_d  = !w_got_d && !bvalid_d;
    arready_d = !rvalid_d;
    // An event in the cycle of a clearing read survives it.
    status_d  = (status_q & ~st_clr) | st_set;
    irq_d     = |(status_d & mask_d);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= dps_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= dps_pkg::RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
      ctrl_q    <= dps_pkg::dps_ctrl_t'(dps_pkg::RST_CTRL);
      period_q  <= dps_pkg::RST_PERIOD;
      mask_q    <= dps_pkg::RST_MASK;
      status_q  <= 3'h0;
      irq_q     <= 1'b0;
      for (int i = 0; i < dps_pkg::NUM_ENTRIES; i++) begin
        entry_q[i] <= dps_pkg::RST_ENTRY;
      end
    end else begin
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      ctrl_q    <= ctrl_d;
      period_q  <= period_d;
      mask_q    <= mask_d;
      status_q  <= status_d;
      irq_q     <= irq_d;
      for (int i = 0; i < dps_pkg::NUM_ENTRIES; i++) begin
        entry_q[i] <= entry_d[i];
      end
    end
  end

  // Outputs straight from flops.
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign poll          = poll_q;
  assign irq           = irq_q;

  // Checks of the scheduler behaviour.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_error_code_form: assert property (state_q == dps_pkg::S_WAIT && resp.valid && is_err
    |=> err_q[15:4] == 12'h280 && err_q[3:0] == $past(resp.status)) // R1
    else $error("Error code not formed in the 0x28 range.");
  a_benign_silent: assert property (state_q == dps_pkg::S_WAIT && resp.valid
    && resp.status inside {4'h0, 4'h8, 4'h9} |=> $stable(err_q)) // R2
    else $error("Benign status was reported as error.");
  a_poll_only_due: assert property ($rose(poll_q.valid)
    |-> $past(cur_mod) == {8'h00, $past(cur.phase)} && $past(cur.en)) // R3 R4 R5 R10
    else $error("Entry polled outside its phase.");
  a_phase_zero_first: assert property ($rose(poll_q.valid)
    |-> ($past(cur.phase) == 8'h00) == !$past(idx_q[3])) // R11
    else $error("Nonzero phase entry polled in first pass.");
  a_phase_readable: assert property (s_axi_arvalid && arready_q
    && s_axi_araddr == dps_pkg::OFF_PHASE |=> s_axi_rdata[31:24] == $past(phase_now[7:0])) // R6
    else $error("Current poll phase not returned.");
  a_task_loads_count: assert property (task_edge |=> left_q == $past(cpt) - 8'h01) // R7
    else $error("Cycles per task not loaded.");
  a_timer_starts: assert property (tick && !busy |=> state_q == dps_pkg::S_SCAN) // R8
    else $error("Timer expiry did not start a cycle.");
  a_drop_flagged: assert property (start_req && busy |=> status_q[dps_pkg::ST_DROPPED]) // R9
    else $error("Dropped cycle not flagged.");
  a_irq_level: assert property (##1 irq_q == |($past(status_d) & $past(mask_d)))
    else $error("Interrupt level mismatch.");

  c_error_seen: cover property (state_q == dps_pkg::S_WAIT && resp.valid && is_err);
  c_cycle_drop: cover property (start_req && busy);
  c_multi_cycle: cover property (tick ##[1:1000] tick);
  c_two_polls: cover property ($rose(poll_q.valid) ##[1:100] $rose(poll_q.valid));

endmodule // dps_scheduler

// ---- dps_scheduler_tb_top.sv ----
// Self-checking testbench of the DP cycle poll scheduler.
`timescale 1ns/1ps

module dps_scheduler_tb_top;
  logic               aclk = 1'b0;
  logic               aresetn, task_start, irq, poll_vq;
  logic [7:0]         s_axi_awaddr, s_axi_araddr, delay_in;
  logic [31:0]        s_axi_wdata, s_axi_rdata, d;
  logic [3:0]         s_axi_wstrb, status_in;
  logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic               s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic               s_axi_rvalid, s_axi_rready;
  logic [1:0]         s_axi_bresp, s_axi_rresp, r;
  dps_pkg::dps_poll_t poll;
  dps_pkg::dps_resp_t resp;
  logic [9:0]         seen_q[$], eq[$];
  int                 failures, n_checks, cnt, dr, div_a[8], ph_a[8];
  bit                 en_a[8], err;

  dps_scheduler dut_u (.*);
  dps_slave_model slv_u (.*);

  // Clock of 5 ns period; it starts low from its declaration.
  always #2.5 aclk = ~aclk;

  // Records every poll as it is raised, with its entry and slave address.
  always @(posedge aclk) begin
    poll_vq <= poll.valid;
    if (aresetn && poll.valid && !poll_vq) seen_q.push_back({poll.entry, poll.slave_addr});
  end

  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic fail_now();
    $display("[FAIL] t=%0t wait ran out got %08h exp %08h", $time, 32'h0, 32'h1);
    failures++;
    complete_run();
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got %08h exp %08h", $time, got, exp);
      failures++;
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t irq got %0h exp %0h", $time, got, exp);
      failures++;
    end
  endtask

  task automatic chk_poll(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t poll got %03h exp %03h", $time, got, exp);
      failures++;
    end
  endtask

  // Write with both channels offered together; each is released when taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit aw_ok, w_ok;
    int k;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 200 && !(aw_ok && w_ok); k++) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    for (k = 0; k < 200 && s_axi_bvalid !== 1'b1; k++) @(posedge aclk);
    if (k == 200 || !(aw_ok && w_ok)) fail_now();
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    // Ready counts only at an edge that saw the request, never in the step that raised it.
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (s_axi_arready !== 1'b1 && k < 200);
    s_axi_arvalid <= 1'b0;
    for (k = 0; k < 200 && s_axi_rvalid !== 1'b1; k++) @(posedge aclk);
    if (k == 200) fail_now();
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] rs;
    axi_wr(a, v, rs);
    chk_reg({30'h0, rs}, {30'h0, dps_pkg::RESP_OKAY});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0]  rs;
    axi_rd(a, v, rs);
    chk_reg(v, exp);
    chk_reg({30'h0, rs}, {30'h0, dps_pkg::RESP_OKAY});
  endtask

  task automatic set_entry(input int i, input int dv, input int ph, input bit en);
    div_a[i] = dv;
    ph_a[i] = ph;
    en_a[i] = en;
    wr(dps_pkg::OFF_ENTRY0 + 8'(4 * i), {en, 8'h00, 7'(16 + i), 8'(ph), 8'(dv)});
  endtask

  // Polls due in cycle c: phase-zero entries first, then the others, each pass by index.
  function automatic void exp_polls(input int c, ref logic [9:0] q[$]);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 8; i++) begin
        if (en_a[i] && c % div_a[i] == ph_a[i] && (ph_a[i] == 0) == (p == 0)) begin
          q.push_back({3'(i), 7'(16 + i)});
        end
      end
    end
  endfunction

  task automatic pulse_start();
    @(posedge aclk);
    task_start <= 1'b1;
    repeat (4) @(posedge aclk);
    task_start <= 1'b0;
  endtask

  // Polls the cycle counter until it reaches n.
  task automatic wait_count(input int n);
    int k;
    for (k = 0; k < 400; k++) begin
      axi_rd(dps_pkg::OFF_PHASE, d, r);
      if (d[15:0] === 16'(n)) break;
    end
    if (k == 400) fail_now();
  endtask

  // Main sequence.
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, task_start} = '0;
    s_axi_wstrb = 4'hF;
    status_in = dps_pkg::DATA_LOW_STATUS;
    delay_in = 8'h00;
    aresetn = 1'b0;
    failures = 0;
    n_checks = 0;
    for (int i = 0; i < 8; i++) begin
      div_a[i] = 1;
      ph_a[i] = 0;
      en_a[i] = 0;
    end
    void'($urandom(32'h3afd));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, an unmapped place and a read-only place.
    rd_chk(dps_pkg::OFF_CTRL, dps_pkg::RST_CTRL);
    rd_chk(dps_pkg::OFF_PERIOD, dps_pkg::RST_PERIOD);
    rd_chk(dps_pkg::OFF_MASK, {29'h0, dps_pkg::RST_MASK});
    for (int i = 0; i < 8; i++) rd_chk(dps_pkg::OFF_ENTRY0 + 8'(4 * i), dps_pkg::RST_ENTRY);
    axi_rd(8'h18, d, r);
    chk_reg({30'h0, r}, {30'h0, dps_pkg::RESP_DECERR});
    axi_wr(8'h44, 32'hFFFF_FFFF, r);
    chk_reg({30'h0, r}, {30'h0, dps_pkg::RESP_DECERR});
    wr(dps_pkg::OFF_STATUS, 32'hFFFF_FFFF);
    rd_chk(dps_pkg::OFF_STATUS, 32'h0);
    // Twice-sampled slave as entries 0 and 1, a single-image slave, a random one.
    set_entry(0, 2, 0, 1);
    set_entry(1, 2, 1, 1);
    set_entry(2, 1, 0, 1);
    dr = 1 + $urandom % 4;
    set_entry(3, dr, $urandom % dr, 1);
    delay_in <= 8'($urandom % 6);
    wr(dps_pkg::OFF_PERIOD, 32'h0000_0190);
    wr(dps_pkg::OFF_CTRL, 32'h0002_0201);
    pulse_start();
    exp_polls(0, eq);
    exp_polls(1, eq);
    wait_count(2);
    chk_reg(d, 32'h0000_0002);
    chk_reg(32'(seen_q.size()), 32'(eq.size()));
    foreach (eq[i]) chk_poll(seen_q[i], eq[i]);
    chk_bit(irq, 1'b0);
    wr(dps_pkg::OFF_MASK, 32'h1);
    repeat (2) @(posedge aclk);
    chk_bit(irq, 1'b1);
    rd_chk(dps_pkg::OFF_STATUS, 32'h1);
    repeat (2) @(posedge aclk);
    chk_bit(irq, 1'b0);
    // Every response code, one single-cycle task each.
    cnt = 2;
    for (int i = 0; i < 4; i++) if (i != 2) set_entry(i, 1, 0, 0);
    wr(dps_pkg::OFF_CTRL, 32'h0003_0101);
    wr(dps_pkg::OFF_MASK, 32'h2);
    for (int s = 0; s < 16; s++) begin
      status_in <= 4'(s);
      err = !(s == 0 || s == 8 || s == 9);
      pulse_start();
      cnt++;
      wait_count(cnt);
      chk_bit(irq, err);
      rd_chk(dps_pkg::OFF_STATUS, {30'h0, err, 1'b1});
      if (err) rd_chk(dps_pkg::OFF_ERRCODE, 32'h0002_2800 | 32'(s));
    end
    // A slow slave keeps the cycle busy while the next task starts.
    status_in <= dps_pkg::DATA_LOW_STATUS;
    delay_in <= 8'h3C;
    pulse_start();
    repeat (1 + $urandom % 8) @(posedge aclk);
    pulse_start();
    wait_count(cnt + 1);
    repeat (100) @(posedge aclk);
    rd_chk(dps_pkg::OFF_PHASE, {8'((cnt + 1) % 3), 8'h00, 16'(cnt + 1)});
    chk_bit(irq, 1'b0);
    wr(dps_pkg::OFF_MASK, 32'h4);
    repeat (2) @(posedge aclk);
    chk_bit(irq, 1'b1);
    rd_chk(dps_pkg::OFF_STATUS, 32'h5);
    complete_run();
  end
endmodule // dps_scheduler_tb_top

// ---- dps_slave_model.sv ----
// Behavioural bus engine standing in for the fieldbus slaves behind the scheduler.
`timescale 1ns/1ps

module dps_slave_model (
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // Poll link
  input  wire dps_pkg::dps_poll_t poll,
  output dps_pkg::dps_resp_t      resp,
  // Answer settings from the bench
  input  wire logic [3:0]         status_in,
  input  wire logic [7:0]         delay_in
);
  logic [7:0] wait_q;
  logic       done_q;

  // Answers each poll once after delay_in cycles.
  // The idle status field toggles every cycle, so a stale code is never mistaken for an answer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_q      <= 8'h00;
      done_q      <= 1'b0;
      resp.valid  <= 1'b0;
      resp.status <= 4'h0;
    end else begin
      resp.valid  <= 1'b0;
      resp.status <= ~resp.status;
      if (!poll.valid) begin
        wait_q <= 8'h00;
        done_q <= 1'b0;
      end else if (!done_q && wait_q >= delay_in) begin
        resp.valid  <= 1'b1;
        resp.status <= status_in;
        done_q      <= 1'b1;
      end else if (!done_q) begin
        wait_q <= wait_q + 8'h01;
      end
    end
  end
endmodule // dps_slave_model
